/* bkpt_if.sv */
`timescale 1ns/1ps
interface bkpt_if;
    import dbg_pkg::*;
    logic enable;
    logic force_sel;
    logic [ADDR_W-1:0] match_addr;
    logic [ADDR_W-1:0] cpu_addr;
    logic addr_valid;
    logic opcode_fetch;
    logic queue_end;
    logic tag_at_end;
    logic force_req;
    logic tag_hit;
    modport ctrl (output enable, force_sel, match_addr, cpu_addr, addr_valid, opcode_fetch, queue_end,
                  tag_at_end, input force_req, tag_hit);
    modport unit (input enable, force_sel, match_addr, cpu_addr, addr_valid, opcode_fetch, queue_end,
                  tag_at_end, output force_req, tag_hit);
endinterface : bkpt_if

/* bkpt_unit.sv */
`timescale 1ns/1ps
module bkpt_unit
    import dbg_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    bkpt_if.unit bp
);
    logic match;
    logic force_r;
    logic tag_r;

    // raw compare, gated by the enable so select and address are ignored when off
    assign match = bp.enable && bp.addr_valid && (bp.cpu_addr == bp.match_addr);

    // force style: request held until the next instruction boundary
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            force_r <= 1'b0;
        end else if (!bp.enable || bp.queue_end) begin
            force_r <= 1'b0;
        end else if (match && bp.force_sel) begin
            force_r <= 1'b1;
        end
    end

    // tag style: mark the fetched opcode; cpu reports when it hits queue end
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            tag_r <= 1'b0;
        end else begin
            tag_r <= match && !bp.force_sel && bp.opcode_fetch;
        end
    end

    assign bp.force_req = force_r && bp.enable;
    assign bp.tag_hit = bp.enable && !bp.force_sel && bp.tag_at_end;

    off_no_bkpt_a: assert property (@(posedge ref_clk) disable iff (rst) !bp.enable |-> !bp.force_req && !bp.tag_hit)
        else $error("breakpoint raised while disabled");
    force_match_a: assert property (@(posedge ref_clk) disable iff (rst)
        match && bp.force_sel && !bp.queue_end ##1 bp.enable && !bp.queue_end |-> bp.force_req)
        else $error("force breakpoint not raised after match");
endmodule : bkpt_unit

/* dbg_pkg.sv */
package dbg_pkg;
    // register offset and field positions
    localparam logic [1:0] DSC_OFFSET = 2'h0;
    localparam int BIT_PERMIT = 7;
    localparam int BIT_ACTIVE = 6;
    localparam int BIT_BKPT_EN = 5;
    localparam int BIT_FORCE_TAG = 4;
    localparam int BIT_CLK_SEL = 3;
    localparam int BIT_WAIT_STOP = 2;
    localparam int BIT_WS_FAIL = 1;
    localparam int BIT_SLOW_FAIL = 0;
    // reset values, ordinary and in background mode
    localparam logic [7:0] DSC_RESET_NORMAL = 8'h00;
    localparam logic [7:0] DSC_RESET_BKGD = 8'hC8;
    // bits that the control write may change
    localparam logic [7:0] DSC_WRITE_MASK = 8'hB8;
    localparam int ADDR_W = 16;
    typedef enum logic [1:0] {
        CMD_NONE,
        CMD_READ_STATUS,
        CMD_WRITE_CONTROL,
        CMD_BACKGROUND
    } dbg_cmd_t;
    typedef enum logic [1:0] {
        MEM_OK,
        MEM_FAIL_WAIT_STOP,
        MEM_FAIL_SLOW
    } mem_result_t;
endpackage : dbg_pkg

/* debug_host_model.sv */
`timescale 1ns/1ps
module debug_host_model (
    input wire logic ref_clk,
    output dbg_pkg::dbg_cmd_t cmd,
    output logic cmd_valid,
    output logic [7:0] cmd_wdata,
    input wire logic [7:0] status_rdata,
    input wire logic status_rvalid
);
    import dbg_pkg::*;
    // idle serial side at time zero
    initial begin
        cmd = CMD_NONE;
        cmd_valid = 1'b0;
        cmd_wdata = 8'h00;
    end
    // one-cycle command launched off the falling edge
    task automatic issue(input dbg_cmd_t c, input logic [7:0] d);
        @(negedge ref_clk);
        cmd = c;
        cmd_valid = 1'b1;
        cmd_wdata = d;
        #1;
    endtask : issue
    // release; data flips so a stale byte never looks valid
    task automatic release_cmd();
        @(negedge ref_clk);
        cmd = CMD_NONE;
        cmd_valid = 1'b0;
        cmd_wdata = ~cmd_wdata;
    endtask : release_cmd
    // plain control write
    task automatic write_ctrl(input logic [7:0] d);
        issue(CMD_WRITE_CONTROL, d);
        release_cmd();
    endtask : write_ctrl
    task automatic permit_write(input logic [7:0] d);
        write_ctrl(d | 8'h80);
    endtask : permit_write
    // status read, caller confirms the answer arrived
    task automatic read_status(output logic [7:0] w, output logic got);
        got = 1'b0;
        w = 8'h00;
        issue(CMD_READ_STATUS, 8'h00);
        release_cmd();
        for (int n = 0; n < 4 && !got; n++) begin
            if (status_rvalid === 1'b1) begin
                got = 1'b1;
                w = status_rdata;
            end else begin
                @(negedge ref_clk);
            end
        end
    endtask : read_status
endmodule : debug_host_model

/* debug_status_control.sv */
`timescale 1ns/1ps
// Function
// - reset in background mode sets permit, active and clock select; others clear
// - permit bit stays set until an ordinary reset
// - permit clear refuses background entry; non-intrusive commands still work
// - bit 6 shows active background mode, read only
// - breakpoint disabled ignores select and match address
// - force select: address match outside a queue end cycle forces background at next instruction boundary
// - tag select: tagged opcode at queue end enters background instead
// - bit 3 picks comm clock: 0 alternate, 1 bus clock; default 0
// - bit 2 reports wait or stop; most commands cannot complete then
// - background command lifts cpu from wait or stop into background
// - bit 1 set when memory command fails from wait or stop
// - bit 0 set when memory command fails on slow access
// - register reachable only through serial debug commands
module debug_status_control
    import dbg_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic reset_in_bkgd,
    input wire dbg_pkg::dbg_cmd_t cmd,
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_wdata,
    output logic [7:0] status_rdata,
    output logic status_rvalid,
    output logic cmd_refused,
    input wire logic cpu_wait_stop,
    input wire logic cpu_exit_bkgd,
    input wire logic mem_done,
    input wire dbg_pkg::mem_result_t mem_result,
    input wire logic [ADDR_W-1:0] bkpt_address,
    input wire logic [ADDR_W-1:0] cpu_addr,
    input wire logic addr_valid,
    input wire logic opcode_fetch,
    input wire logic queue_end,
    input wire logic tag_at_end,
    output logic enter_bkgd,
    output logic swi_instead,
    output logic wake_cpu,
    output logic comm_clock_select
);
    logic background_permit_r;
    logic background_active_flag_r;
    logic breakpoint_enable_r;
    logic force_tag_select_r;
    logic comm_clock_select_r;
    logic wait_stop_failure_flag_r;
    logic slow_access_failure_flag_r;
    logic bkgd_seen_r;
    logic wr_ctrl;
    logic bg_cmd;
    logic bkpt_req;
    logic bkpt_seen;
    logic [7:0] status_word;
    logic [7:0] wr_eff;

    bkpt_if bp ();

    // breakpoint logic runs off the control bits
    assign bp.enable = breakpoint_enable_r;
    assign bp.force_sel = force_tag_select_r;
    assign bp.match_addr = bkpt_address;
    assign bp.cpu_addr = cpu_addr;
    assign bp.addr_valid = addr_valid;
    assign bp.opcode_fetch = opcode_fetch;
    assign bp.queue_end = queue_end;
    assign bp.tag_at_end = tag_at_end;

    bkpt_unit u_bkpt (
        .ref_clk(ref_clk),
        .rst(rst),
        .bp(bp)
    );

    assign wr_ctrl = cmd_valid && (cmd == CMD_WRITE_CONTROL);
    assign bg_cmd = cmd_valid && (cmd == CMD_BACKGROUND);

    assign wr_eff = cmd_wdata & DSC_WRITE_MASK;

    assign bkpt_seen = (bp.force_req && queue_end) || bp.tag_hit;

    assign bkpt_req = (bkpt_seen || bg_cmd) && background_permit_r && !background_active_flag_r;
    assign enter_bkgd = bkpt_req;
    // without permit the cpu takes a software interrupt instead
    assign swi_instead = bkpt_seen && !background_permit_r;
    assign cmd_refused = bg_cmd && !background_permit_r;
    assign wake_cpu = bg_cmd && background_permit_r && cpu_wait_stop;

    // strap sampled after release by clocked logic, not in the async branch
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            bkgd_seen_r <= 1'b0;
        end else begin
            bkgd_seen_r <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            background_permit_r <= DSC_RESET_NORMAL[BIT_PERMIT];
            breakpoint_enable_r <= DSC_RESET_NORMAL[BIT_BKPT_EN];
            force_tag_select_r <= DSC_RESET_NORMAL[BIT_FORCE_TAG];
            comm_clock_select_r <= DSC_RESET_NORMAL[BIT_CLK_SEL];
        end else if (!bkgd_seen_r && reset_in_bkgd) begin
            background_permit_r <= DSC_RESET_BKGD[BIT_PERMIT];
            breakpoint_enable_r <= DSC_RESET_BKGD[BIT_BKPT_EN];
            force_tag_select_r <= DSC_RESET_BKGD[BIT_FORCE_TAG];
            comm_clock_select_r <= DSC_RESET_BKGD[BIT_CLK_SEL];
        end else if (wr_ctrl) begin
            background_permit_r <= background_permit_r | wr_eff[BIT_PERMIT];
            breakpoint_enable_r <= wr_eff[BIT_BKPT_EN];
            force_tag_select_r <= wr_eff[BIT_FORCE_TAG];
            comm_clock_select_r <= wr_eff[BIT_CLK_SEL];
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            background_active_flag_r <= DSC_RESET_NORMAL[BIT_ACTIVE];
        end else if (!bkgd_seen_r && reset_in_bkgd) begin
            background_active_flag_r <= DSC_RESET_BKGD[BIT_ACTIVE];
        end else if (bkpt_req) begin
            background_active_flag_r <= 1'b1;
        end else if (cpu_exit_bkgd) begin
            background_active_flag_r <= 1'b0;
        end
    end

    // wait or stop failure and slow access failure
    // each memory command result replaces the flags; a fail always sets
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wait_stop_failure_flag_r <= DSC_RESET_NORMAL[BIT_WS_FAIL];
            slow_access_failure_flag_r <= DSC_RESET_NORMAL[BIT_SLOW_FAIL];
        end else if (mem_done) begin
            wait_stop_failure_flag_r <= (mem_result == MEM_FAIL_WAIT_STOP);
            slow_access_failure_flag_r <= (mem_result == MEM_FAIL_SLOW);
        end
    end

    always_comb begin
        status_word = 8'h00;
        status_word[BIT_PERMIT] = background_permit_r;
        status_word[BIT_ACTIVE] = background_active_flag_r;
        status_word[BIT_BKPT_EN] = breakpoint_enable_r;
        status_word[BIT_FORCE_TAG] = force_tag_select_r;
        status_word[BIT_CLK_SEL] = comm_clock_select_r;
        status_word[BIT_WAIT_STOP] = cpu_wait_stop;
        status_word[BIT_WS_FAIL] = wait_stop_failure_flag_r;
        status_word[BIT_SLOW_FAIL] = slow_access_failure_flag_r;
    end

    // status read answer registered one cycle after the command
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            status_rdata <= 8'h00;
            status_rvalid <= 1'b0;
        end else begin
            status_rvalid <= cmd_valid && (cmd == CMD_READ_STATUS);
            if (cmd_valid && (cmd == CMD_READ_STATUS)) begin
                status_rdata <= status_word;
            end
        end
    end

    assign comm_clock_select = comm_clock_select_r;

    permit_sticky_a: assert property (@(posedge ref_clk) disable iff (rst)
        background_permit_r |=> background_permit_r)
        else $error("permit bit cleared without reset");
    no_entry_a: assert property (@(posedge ref_clk) disable iff (rst)
        !background_permit_r && !background_active_flag_r && !(!bkgd_seen_r && reset_in_bkgd)
        |=> !background_active_flag_r)
        else $error("background entered without permit");
    active_set_a: assert property (@(posedge ref_clk) disable iff (rst)
        enter_bkgd |=> background_active_flag_r)
        else $error("active flag not set on entry");
    bkgd_reset_a: assert property (@(posedge ref_clk) disable iff (rst)
        !bkgd_seen_r && reset_in_bkgd |=> background_permit_r && background_active_flag_r
        && comm_clock_select_r && !breakpoint_enable_r)
        else $error("background reset values wrong");
    ro_write_a: assert property (@(posedge ref_clk) disable iff (rst)
        wr_ctrl && !mem_done && !bkpt_req && !cpu_exit_bkgd && bkgd_seen_r
        |=> $stable(wait_stop_failure_flag_r) && $stable(background_active_flag_r))
        else $error("control write changed status bit");
    sequence ws_fail_s;
        mem_done && mem_result == MEM_FAIL_WAIT_STOP;
    endsequence
    // the flag must show on the edge after the result, so the very next read reports it
    ws_fail_a: assert property (@(posedge ref_clk) disable iff (rst)
        ws_fail_s |=> wait_stop_failure_flag_r && status_word[BIT_WS_FAIL])
        else $error("wait stop failure not reported");
    slow_ok_a: assert property (@(posedge ref_clk) disable iff (rst)
        mem_done && mem_result == MEM_OK |=> !slow_access_failure_flag_r)
        else $error("slow access flag set without failure");
    ws_read_a: assert property (@(posedge ref_clk) disable iff (rst)
        cmd_valid && cmd == CMD_READ_STATUS |=> status_rvalid && status_rdata[BIT_WAIT_STOP] == $past(cpu_wait_stop))
        else $error("wait stop bit misreported");
    wake_a: assert property (@(posedge ref_clk) disable iff (rst)
        bg_cmd && background_permit_r && cpu_wait_stop |-> wake_cpu && enter_bkgd | background_active_flag_r)
        else $error("background command did not wake cpu");
endmodule : debug_status_control

/* test_background_debug_status_control.sv */
`timescale 1ns/1ps
module test_background_debug_status_control;
    import dbg_pkg::*;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic reset_in_bkgd = 1'b0;
    logic cpu_wait_stop = 1'b0;
    logic cpu_exit_bkgd = 1'b0;
    logic mem_done = 1'b0;
    mem_result_t mem_result = MEM_OK;
    logic [15:0] bkpt_address = 16'h0000;
    logic [15:0] cpu_addr = 16'h0000;
    logic addr_valid = 1'b0;
    logic opcode_fetch = 1'b0;
    logic queue_end = 1'b0;
    logic tag_at_end = 1'b0;
    dbg_cmd_t cmd;
    logic cmd_valid, status_rvalid, cmd_refused, enter_bkgd, swi_instead, wake_cpu, comm_clock_select;
    logic [7:0] cmd_wdata, status_rdata;
    int miscompares = 0;
    int checks_done = 0;
    localparam logic [7:0] BP_CTRL [5] = '{8'hB0, 8'hA0, 8'h90, 8'h80, 8'hB0};
    always #5 ref_clk = ~ref_clk;
    debug_status_control DUT (.ref_clk(ref_clk), .rst(rst), .reset_in_bkgd(reset_in_bkgd), .cmd(cmd),
        .cmd_valid(cmd_valid), .cmd_wdata(cmd_wdata), .status_rdata(status_rdata), .status_rvalid(status_rvalid),
        .cmd_refused(cmd_refused), .cpu_wait_stop(cpu_wait_stop), .cpu_exit_bkgd(cpu_exit_bkgd),
        .mem_done(mem_done), .mem_result(mem_result), .bkpt_address(bkpt_address), .cpu_addr(cpu_addr),
        .addr_valid(addr_valid), .opcode_fetch(opcode_fetch), .queue_end(queue_end), .tag_at_end(tag_at_end),
        .enter_bkgd(enter_bkgd), .swi_instead(swi_instead), .wake_cpu(wake_cpu),
        .comm_clock_select(comm_clock_select));
    debug_host_model host (.ref_clk(ref_clk), .cmd(cmd), .cmd_valid(cmd_valid), .cmd_wdata(cmd_wdata),
        .status_rdata(status_rdata), .status_rvalid(status_rvalid));
    // compare helpers, one per result kind
    task automatic check_bit(input string name, input logic exp, input logic seen);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error %s expected %b seen %b", name, exp, seen);
        end
    endtask : check_bit
    task automatic check_word(input string name, input logic [7:0] exp, input logic [7:0] seen);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check_word
    task automatic expect_status(input string name, input logic [7:0] exp);
        logic [7:0] w;
        logic got;
        host.read_status(w, got);
        check_bit(name, 1'b1, got);
        check_word(name, exp, w);
    endtask : expect_status
    // failure flags expected for a memory result
    function automatic logic [7:0] fail_bits(input int r);
        return (r == 1) ? 8'h02 : (r == 2) ? 8'h01 : 8'h00;
    endfunction : fail_bits
    task automatic do_reset(input logic in_bkgd);
        @(negedge ref_clk);
        rst = 1'b1;
        reset_in_bkgd = in_bkgd;
        repeat (3) @(negedge ref_clk);
        rst = 1'b0;
        repeat (2) @(negedge ref_clk);
        reset_in_bkgd = 1'b0;
    endtask : do_reset
    task automatic pulse(ref logic s);
        @(negedge ref_clk);
        s = 1'b1;
        @(negedge ref_clk);
        s = 1'b0;
    endtask : pulse
    // one cpu bus cycle, then an instruction boundary or tagged end
    task automatic bus_then_end(input logic [15:0] a, input logic tag, output logic e, output logic s);
        @(negedge ref_clk);
        cpu_addr = a;
        addr_valid = 1'b1;
        opcode_fetch = tag;
        @(negedge ref_clk);
        addr_valid = 1'b0;
        opcode_fetch = 1'b0;
        cpu_addr = ~a;
        queue_end = !tag;
        tag_at_end = tag;
        #1;
        e = enter_bkgd;
        s = swi_instead;
        @(negedge ref_clk);
        queue_end = 1'b0;
        tag_at_end = 1'b0;
    endtask : bus_then_end
    task automatic end_sim();
        $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_sim
    // watchdog, far beyond the hundred or so cycles the run needs
    initial begin
        #50000;
        miscompares++;
        end_sim();
    end
    initial begin
        logic e, s;
        logic [7:0] d;
        d = 8'($urandom(32'h980C2414));
        bkpt_address = 16'($urandom);
        d = 8'($urandom);
        do_reset(1'b0);
        expect_status("reset word", 8'h00);
        check_bit("clock default", 1'b0, comm_clock_select);
        host.issue(CMD_BACKGROUND, 8'h00);
        check_bit("refused", 1'b1, cmd_refused);
        check_bit("no entry", 1'b0, enter_bkgd);
        host.release_cmd();
        // breakpoint without permit becomes a software interrupt
        host.write_ctrl(8'h30);
        bus_then_end(bkpt_address, 1'b0, e, s);
        check_bit("swi", 1'b1, s);
        check_bit("swi entry", 1'b0, e);
        host.permit_write(d);
        expect_status("masked write", (d | 8'h80) & DSC_WRITE_MASK);
        check_bit("clock select", d[3], comm_clock_select);
        host.write_ctrl(8'h00);
        expect_status("permit sticks", 8'h80);
        cpu_wait_stop = 1'b1;
        host.issue(CMD_BACKGROUND, 8'h00);
        check_bit("bkgd entry", 1'b1, enter_bkgd);
        check_bit("wake", 1'b1, wake_cpu);
        host.release_cmd();
        expect_status("active in wait", 8'hC4);
        cpu_wait_stop = 1'b0;
        pulse(cpu_exit_bkgd);
        expect_status("after exit", 8'h80);
        // last result is a success so the flags must clear
        for (int i = 2; i >= 0; i--) begin
            mem_result = mem_result_t'(i);
            pulse(mem_done);
            expect_status("memory flags", 8'h80 | fail_bits(i));
        end
        // force, tag, disabled twice, force with a miss
        for (int i = 0; i < 5; i++) begin
            host.write_ctrl(BP_CTRL[i]);
            bus_then_end((i == 4) ? ~bkpt_address : bkpt_address, !BP_CTRL[i][4], e, s);
            check_bit("breakpoint", BP_CTRL[i][5] && i != 4, e);
            pulse(cpu_exit_bkgd);
        end
        do_reset(1'b1);
        expect_status("bkgd reset word", DSC_RESET_BKGD);
        check_bit("bkgd clock", 1'b1, comm_clock_select);
        do_reset(1'b0);
        expect_status("ordinary reset", 8'h00);
        end_sim();
    end
endmodule : test_background_debug_status_control
